// ===== common/cfg_regs_pkg.sv
package cfg_regs_pkg;

  // ------------------------------------------------------------
  // register map and presets
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W          = 5;
  localparam int unsigned DATA_W          = 8;
  localparam logic [4:0]  POWER_CTRL_ADDR = 5'h00;
  localparam logic [4:0]  PROTO_SEL_ADDR  = 5'h01;
  localparam logic [7:0]  POWER_CTRL_RST  = 8'h01;
  localparam logic [7:0]  PROTO_SEL_RST   = 8'h02;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
  localparam logic [7:0]  POWER_CTRL_MASK = 8'hFB;  // bit 2 is reserved

  // ------------------------------------------------------------
  // power and rf control field positions
  // ------------------------------------------------------------
  localparam int unsigned PC_STANDBY  = 7;
  localparam int unsigned PC_RAW      = 6;
  localparam int unsigned PC_TX_ON    = 5;
  localparam int unsigned PC_HALF_PWR = 4;
  localparam int unsigned PC_AUX_RX   = 3;
  localparam int unsigned PC_RESERVED = 2;
  localparam int unsigned PC_RX_FORCE = 1;
  localparam int unsigned PC_SUPPLY5V = 0;

  // ------------------------------------------------------------
  // protocol select field positions
  // ------------------------------------------------------------
  localparam int unsigned PS_NO_CRC   = 7;
  localparam int unsigned PS_RAW_TYPE = 6;
  localparam int unsigned PS_NFC      = 5;
  localparam int unsigned PS_ROLE     = 4;
  localparam int unsigned PS_ACTIVE   = 3;
  localparam int unsigned PS_CARD_EMU = 2;

  // ------------------------------------------------------------
  // decoded protocol classes and bit rates
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_VICINITY    = 3'h0,
    CLS_PROX_A      = 3'h1,
    CLS_PROX_B      = 3'h2,
    CLS_PROPRIETARY = 3'h3,
    CLS_NFC         = 3'h4,
    CLS_CARD_EMU_A  = 3'h5,
    CLS_CARD_EMU_B  = 3'h6,
    CLS_RESERVED    = 3'h7
  } proto_class_t;

  typedef enum logic [1:0] {
    RATE_106 = 2'h0,
    RATE_212 = 2'h1,
    RATE_424 = 2'h2,
    RATE_848 = 2'h3
  } rate_t;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [4:0]       addr;
    logic [7:0]       wdata;
  } host_req_t;

  typedef struct packed {
    logic standby;
    logic active;
    logic framing_enable;
    logic raw_mode0;
    logic raw_mode1;
    logic transmitter_enable;
    logic receiver_enable;
    logic tx_osc_force;
    logic output_power_half;
    logic aux_receive_input_select;
    logic supply_range_select;
  } rf_ctrl_t;

  typedef struct packed {
    proto_class_t cls;
    rate_t        rate;
    logic         valid;
    logic         crc_check;
    logic         vic_double_sub;
    logic         vic_high_rate;
    logic         vic_one_of_256;
    logic         nfc_initiator;
    logic         nfc_active;
  } proto_cfg_t;

endpackage

// ===== hdl/main_config_regs.sv
`timescale 1ns/100ps
// How it works
// - standby bit 7 set keeps device in standby, clear means active
// - power control register presets to 0x01 at reset or chip enable low
// - raw access bit 6 bypasses framing; mode 0 front end, mode 1 custom framing
// - raw access clear gives host port exchange with automatic framing
// - bit 5 switches transmitter and receivers on, clear keeps transmitter off
// - bit 4 set selects half power, clear selects full power
// - bit 3 routes receiver to auxiliary input when set, main otherwise
// - bit 1 forces receiver and oscillator on; else receiver follows bit 5
// - protocol bit 7 clear means crc checked, only for type A and vicinity
// - protocol bit 6 chooses direct mode type 0 or 1
// - protocol bit 5 chooses reader mode or nfc and card emulation
// - reader: bits 4..0 form protocol code; nfc: bit 4 picks initiator
// - nfc: bit 3 picks passive or active communication
// - nfc family: bit 2 picks normal nfc or card emulation
// - nfc family: bits 1..0 pick bit rate or emulated card type
// - protocol register presets to 0x02 at reset or chip enable low
// - low code bits decode nfc rates and card emulation types
// - reader codes decode vicinity, type A, type B, proprietary protocols
// - writing protocol register reloads option register defaults
module main_config_regs
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic                   chip_enable_pin,
  input  wire cfg_regs_pkg::host_req_t host_req,
  output logic [7:0]                  rdata,
  output logic                        rvalid,
  output cfg_regs_pkg::rf_ctrl_t      rf_ctrl,
  output cfg_regs_pkg::proto_cfg_t    proto_cfg,
  output logic                        option_reload
);
  import cfg_regs_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic       en_meta_reg;
  logic       en_sync_reg;
  logic [7:0] power_reg;
  logic [7:0] power_next;
  logic [7:0] proto_reg;
  logic [7:0] proto_next;
  logic       wr_power;
  logic       wr_proto;
  logic [7:0] rdata_next;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------

  // power register to front-end controls
  function automatic rf_ctrl_t decode_power(input logic [7:0] p);
    rf_ctrl_t c;
    c.standby                  = p[PC_STANDBY];
    c.active                   = ~p[PC_STANDBY];
    c.framing_enable           = ~p[PC_RAW];
    c.raw_mode0                = 1'b0;
    c.raw_mode1                = 1'b0;
    c.transmitter_enable       = p[PC_TX_ON];
    c.receiver_enable          = p[PC_TX_ON] | p[PC_RX_FORCE];
    c.tx_osc_force             = p[PC_RX_FORCE];
    c.output_power_half        = p[PC_HALF_PWR];
    c.aux_receive_input_select = p[PC_AUX_RX];
    c.supply_range_select      = p[PC_SUPPLY5V];
    return c;
  endfunction

  // protocol register to protocol configuration
  function automatic proto_cfg_t decode_proto(input logic [7:0] s);
    proto_cfg_t c;
    c.cls            = CLS_RESERVED;
    c.rate           = rate_t'(s[1:0]);
    c.valid          = 1'b0;
    c.crc_check      = 1'b0;
    c.vic_double_sub = 1'b0;
    c.vic_high_rate  = 1'b0;
    c.vic_one_of_256 = 1'b0;
    c.nfc_initiator  = 1'b0;
    c.nfc_active     = 1'b0;
    if (!s[PS_NFC])
    begin
      // reader mode: five-bit protocol code
      if (s[4:3] == 2'b00)
      begin
        c.cls            = CLS_VICINITY;
        c.valid          = 1'b1;
        c.vic_double_sub = s[2];
        c.vic_high_rate  = s[1];
        c.vic_one_of_256 = s[0];
      end
      else if (s[4:2] == 3'b010)
      begin
        c.cls   = CLS_PROX_A;
        c.valid = 1'b1;
      end
      else if (s[4:2] == 3'b011)
      begin
        c.cls   = CLS_PROX_B;
        c.valid = 1'b1;
      end
      else if (s[4:1] == 4'b1101)
      begin
        c.cls   = CLS_PROPRIETARY;
        c.valid = 1'b1;
        c.rate  = s[0] ? RATE_424 : RATE_212;
      end
      // crc only meaningful for type A and vicinity
      c.crc_check = ~s[PS_NO_CRC] & c.valid
                  & (c.cls == CLS_VICINITY || c.cls == CLS_PROX_A);
    end
    else if (!s[PS_CARD_EMU])
    begin
      // nfc: role, communication mode, bit rate
      c.cls           = CLS_NFC;
      c.nfc_initiator = s[PS_ROLE];
      c.nfc_active    = s[PS_ACTIVE];
      c.valid         = (s[1:0] != 2'b00);
      c.rate          = rate_t'(s[1:0] - 2'h1);
    end
    else
    begin
      // card emulation: emulated card type
      c.cls   = s[0] ? CLS_CARD_EMU_B : CLS_CARD_EMU_A;
      c.valid = (s[1] == 1'b0);
      c.rate  = RATE_106;
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // chip enable pin synchroniser
  // ------------------------------------------------------------

  // low until synchronised so registers stay preset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end
    else if (ce)
    begin
      en_meta_reg <= chip_enable_pin;
      en_sync_reg <= en_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------

  // writes land only while the chip is enabled
  assign wr_power = host_req.wr && en_sync_reg && (host_req.addr == POWER_CTRL_ADDR);
  assign wr_proto = host_req.wr && en_sync_reg && (host_req.addr == PROTO_SEL_ADDR);

  // next values, preset while chip enable is low
  always_comb
  begin
    power_next = power_reg;
    proto_next = proto_reg;
    if (!en_sync_reg)
    begin
      power_next = POWER_CTRL_RST;
      proto_next = PROTO_SEL_RST;
    end
    else
    begin
      if (wr_power)
      begin
        power_next = host_req.wdata & POWER_CTRL_MASK;
      end
      if (wr_proto)
      begin
        proto_next = host_req.wdata;
      end
    end
  end

  // power and rf control register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      power_reg <= POWER_CTRL_RST;
    end
    else if (ce)
    begin
      power_reg <= power_next;
    end
  end

  // protocol select register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      proto_reg <= PROTO_SEL_RST;
    end
    else if (ce)
    begin
      proto_reg <= proto_next;
    end
  end

  // ------------------------------------------------------------
  // decoded outputs, aligned with the registers
  // ------------------------------------------------------------

  // front-end controls; raw mode type comes from protocol register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rf_ctrl <= decode_power(POWER_CTRL_RST);
    end
    else if (ce)
    begin
      rf_ctrl           <= decode_power(power_next);
      rf_ctrl.raw_mode0 <= power_next[PC_RAW] & ~proto_next[PS_RAW_TYPE];
      rf_ctrl.raw_mode1 <= power_next[PC_RAW] & proto_next[PS_RAW_TYPE];
    end
  end

  // protocol configuration
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      proto_cfg <= decode_proto(PROTO_SEL_RST);
    end
    else if (ce)
    begin
      proto_cfg <= decode_proto(proto_next);
    end
  end

  // one-cycle reload of option register defaults
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      option_reload <= 1'b0;
    end
    else if (ce)
    begin
      option_reload <= wr_proto;
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------

  // read mux, unmapped addresses read zero
  always_comb
  begin
    unique case (host_req.addr)
      POWER_CTRL_ADDR: rdata_next = power_reg;
      PROTO_SEL_ADDR:  rdata_next = proto_reg;
      default:         rdata_next = UNMAPPED_READ;
    endcase
  end

  // read data and its one-cycle strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end
    else if (ce)
    begin
      rvalid <= host_req.rd;
      if (host_req.rd)
      begin
        rdata <= rdata_next;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence proto_write_s;
    ce && wr_proto;
  endsequence

  // a frozen clock enable holds the pulse, so that cycle is excused
  sequence reload_pulse_s;
    option_reload ##1 (!option_reload || $past(wr_proto) || !$past(ce));
  endsequence

  standby_follows_a: assert property (rf_ctrl.standby == power_reg[7]
                                      && rf_ctrl.active != power_reg[7])
    else $error("standby output does not follow bit 7");
  power_preset_a: assert property ((ce && !en_sync_reg) |=> power_reg == 8'h01)
    else $error("power register not preset while disabled");
  raw_mode_a: assert property (rf_ctrl.raw_mode1 == (power_reg[6] && proto_reg[6])
                               && rf_ctrl.raw_mode0 == (power_reg[6] && !proto_reg[6]))
    else $error("raw mode outputs wrong");
  framing_on_a: assert property (rf_ctrl.framing_enable == !power_reg[6])
    else $error("framing enable wrong");
  tx_enable_a: assert property (rf_ctrl.transmitter_enable == power_reg[5])
    else $error("transmitter enable wrong");
  half_power_a: assert property (rf_ctrl.output_power_half == power_reg[4])
    else $error("output power select wrong");
  aux_input_a: assert property (rf_ctrl.aux_receive_input_select == power_reg[3])
    else $error("receive input select wrong");
  rx_force_a: assert property (rf_ctrl.receiver_enable == (power_reg[5] || power_reg[1]))
    else $error("receiver enable wrong");
  supply_sel_a: assert property (rf_ctrl.supply_range_select == power_reg[0])
    else $error("supply range select wrong");
  crc_check_a: assert property (proto_cfg.crc_check |-> !proto_reg[7] && !proto_reg[5])
    else $error("crc checked when not selected");
  family_sel_a: assert property (proto_reg[5] == (proto_cfg.cls inside {CLS_NFC,
                                 CLS_CARD_EMU_A, CLS_CARD_EMU_B}))
    else $error("protocol family wrong");
  nfc_role_a: assert property ((proto_cfg.cls == CLS_NFC)
                               |-> proto_cfg.nfc_initiator == proto_reg[4]
                               && proto_cfg.nfc_active == proto_reg[3])
    else $error("nfc role or mode wrong");
  proto_preset_a: assert property ((ce && !en_sync_reg) |=> proto_reg == 8'h02
                                   && proto_cfg.cls == CLS_VICINITY && proto_cfg.vic_high_rate)
    else $error("protocol register not preset while disabled");
  nfc_rate_a: assert property ((proto_cfg.cls == CLS_NFC && proto_reg[1:0] == 2'b11)
                               |-> proto_cfg.rate == RATE_424 && proto_cfg.valid)
    else $error("nfc 424 rate decode wrong");
  proprietary_a: assert property ((!proto_reg[5] && proto_reg[4:0] == 5'b11010)
                                  |-> proto_cfg.cls == CLS_PROPRIETARY
                                  && proto_cfg.rate == RATE_212)
    else $error("proprietary protocol decode wrong");
  reload_write_a: assert property (proto_write_s |=> reload_pulse_s
                                   and proto_reg == $past(host_req.wdata))
    else $error("protocol write did not reload options");
  reserved_zero_a: assert property (!power_reg[2])
    else $error("reserved bit reads non-zero");
  read_strobe_a: assert property ((ce && host_req.rd) |=> rvalid
                                  ##1 (rvalid == $past(host_req.rd, 1) || !$past(ce)))
    else $error("read strobe missing");

endmodule

// ===== verif/host_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// host controller on the byte-wide register port
// ------------------------------------------------------------
module host_model
(
  input  wire logic                    clk,
  output cfg_regs_pkg::host_req_t      host_req,
  input  wire logic [7:0]              rdata,
  input  wire logic                    rvalid
);
  import cfg_regs_pkg::*;

  // idle port, address and data parked at a junk value
  initial host_req = '{wr: 1'b0, rd: 1'b0, addr: 5'h1F, wdata: 8'hA5};

  // one write strobe, released with inverted address and data
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    host_req.wr    = 1'b1;
    host_req.addr  = a;
    host_req.wdata = d;
    @(negedge clk);
    host_req.wr    = 1'b0;
    host_req.addr  = ~a;
    host_req.wdata = ~d;
  endtask

  // one read strobe, answer taken in the cycle after the edge
  task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    host_req.rd   = 1'b1;
    host_req.addr = a;
    @(negedge clk);
    d             = rdata;
    v             = rvalid;
    host_req.rd   = 1'b0;
    host_req.addr = ~a;
  endtask
endmodule

// ===== verif/tb_nfc_reader_main_config_regs.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module tb_nfc_reader_main_config_regs;
  import cfg_regs_pkg::*;

  logic       clk;
  logic       nrst;
  logic       ce;
  logic       chip_enable_pin;
  host_req_t  host_req;
  logic [7:0] rdata;
  logic       rvalid;
  rf_ctrl_t   rf_ctrl;
  proto_cfg_t proto_cfg;
  logic       option_reload;
  int         miscompares;
  int         num_checks;
  logic [7:0] proto_now;

  // ------------------------------------------------------------
  // design, host and clock
  // ------------------------------------------------------------
  main_config_regs uut (.clk(clk), .nrst(nrst), .ce(ce), .chip_enable_pin(chip_enable_pin),
    .host_req(host_req), .rdata(rdata), .rvalid(rvalid), .rf_ctrl(rf_ctrl),
    .proto_cfg(proto_cfg), .option_reload(option_reload));

  host_model host (.clk(clk), .host_req(host_req), .rdata(rdata), .rvalid(rvalid));

  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // expectations and shared steps
  // ------------------------------------------------------------
  function automatic rf_ctrl_t exp_rf(input logic [7:0] v, input logic [7:0] p);
    rf_ctrl_t r;
    r.standby                  = v[7];
    r.active                   = ~v[7];
    r.framing_enable           = ~v[6];
    r.raw_mode0                = v[6] & ~p[6];
    r.raw_mode1                = v[6] & p[6];
    r.transmitter_enable       = v[5];
    r.receiver_enable          = v[5] | v[1];
    r.tx_osc_force             = v[1];
    r.output_power_half        = v[4];
    r.aux_receive_input_select = v[3];
    r.supply_range_select      = v[0];
    return r;
  endfunction

  task automatic check_reg(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.read_reg(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", exp, d)
  endtask

  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst      = 1'b1;
    proto_now = PROTO_SEL_RST;
    repeat (4) @(negedge clk);
  endtask

  task automatic judge_proto(input logic [7:0] c, input proto_class_t cls, input rate_t rt,
                             input logic vld, input logic crc);
    `CHK("valid", vld, proto_cfg.valid)
    if (vld)
    begin
      `CHK("class", cls, proto_cfg.cls)
      `CHK("crc", crc, proto_cfg.crc_check)
    end
    if (vld && cls != CLS_VICINITY)
      `CHK("rate", rt, proto_cfg.rate)
    if (vld && cls == CLS_VICINITY)
    begin
      `CHK("vic_sub", c[2], proto_cfg.vic_double_sub)
      `CHK("vic_rate", c[1], proto_cfg.vic_high_rate)
      `CHK("vic_256", c[0], proto_cfg.vic_one_of_256)
    end
    if (vld && cls == CLS_NFC)
    begin
      `CHK("initiator", c[4], proto_cfg.nfc_initiator)
      `CHK("active", c[3], proto_cfg.nfc_active)
    end
  endtask

  task automatic t_proto(input logic [7:0] c, input proto_class_t cls, input rate_t rt,
                         input logic vld, input logic crc);
    host.write_reg(PROTO_SEL_ADDR, c);
    proto_now = c;
    `CHK("reload", 1'b1, option_reload)
    check_reg(PROTO_SEL_ADDR, c);
    `CHK("reload_end", 1'b0, option_reload)
    judge_proto(c, cls, rt, vld, crc);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_presets();
    check_reg(POWER_CTRL_ADDR, POWER_CTRL_RST);
    check_reg(PROTO_SEL_ADDR, PROTO_SEL_RST);
    `CHK("rf_preset", exp_rf(8'h01, 8'h02), rf_ctrl)
    judge_proto(8'h02, CLS_VICINITY, RATE_106, 1'b1, 1'b1);
    $display("t_presets done");
  endtask

  task automatic t_power();
    logic [7:0] v;
    for (int b = 0; b < 9; b++)
    begin
      v = (b == 8) ? 8'hFF : (8'h01 << b);
      host.write_reg(POWER_CTRL_ADDR, v);
      check_reg(POWER_CTRL_ADDR, v & 8'hFB);
      `CHK("rf_ctrl", exp_rf(v, proto_now), rf_ctrl)
    end
    $display("t_power done");
  endtask

  task automatic t_protocols();
    t_proto(8'h05, CLS_VICINITY, RATE_106, 1'b1, 1'b1);
    t_proto(8'h07, CLS_VICINITY, RATE_106, 1'b1, 1'b1);
    t_proto(8'h08, CLS_PROX_A, RATE_106, 1'b1, 1'b1);
    t_proto(8'h0B, CLS_PROX_A, RATE_848, 1'b1, 1'b1);
    t_proto(8'h09, CLS_PROX_A, RATE_212, 1'b1, 1'b1);
    t_proto(8'h0A, CLS_PROX_A, RATE_424, 1'b1, 1'b1);
    t_proto(8'h82, CLS_VICINITY, RATE_106, 1'b1, 1'b0);
    t_proto(8'h88, CLS_PROX_A, RATE_106, 1'b1, 1'b0);
    t_proto(8'h0E, CLS_PROX_B, RATE_424, 1'b1, 1'b0);
    t_proto(8'h0F, CLS_PROX_B, RATE_848, 1'b1, 1'b0);
    t_proto(8'h0C, CLS_PROX_B, RATE_106, 1'b1, 1'b0);
    t_proto(8'h0D, CLS_PROX_B, RATE_212, 1'b1, 1'b0);
    t_proto(8'h1A, CLS_PROPRIETARY, RATE_212, 1'b1, 1'b0);
    t_proto(8'h1B, CLS_PROPRIETARY, RATE_424, 1'b1, 1'b0);
    t_proto(8'h13, CLS_RESERVED, RATE_106, 1'b0, 1'b0);
    t_proto(8'h1C, CLS_RESERVED, RATE_106, 1'b0, 1'b0);
    t_proto(8'h21, CLS_NFC, RATE_106, 1'b1, 1'b0);
    t_proto(8'h2A, CLS_NFC, RATE_212, 1'b1, 1'b0);
    t_proto(8'h3B, CLS_NFC, RATE_424, 1'b1, 1'b0);
    t_proto(8'h20, CLS_NFC, RATE_106, 1'b0, 1'b0);
    t_proto(8'h24, CLS_CARD_EMU_A, RATE_106, 1'b1, 1'b0);
    t_proto(8'h25, CLS_CARD_EMU_B, RATE_106, 1'b1, 1'b0);
    t_proto(8'h26, CLS_CARD_EMU_A, RATE_106, 1'b0, 1'b0);
    t_proto(8'h27, CLS_CARD_EMU_B, RATE_106, 1'b0, 1'b0);
    $display("t_protocols done");
  endtask

  task automatic t_raw();
    t_proto(8'h42, CLS_VICINITY, RATE_106, 1'b1, 1'b1);
    host.write_reg(POWER_CTRL_ADDR, 8'h40);
    `CHK("raw_mode1", exp_rf(8'h40, 8'h42), rf_ctrl)
    t_proto(8'h02, CLS_VICINITY, RATE_106, 1'b1, 1'b1);
    `CHK("raw_mode0", exp_rf(8'h40, 8'h02), rf_ctrl)
    $display("t_raw done");
  endtask

  task automatic t_refused();
    host.write_reg(5'h05, 8'hFF);
    check_reg(5'h05, UNMAPPED_READ);
    check_reg(POWER_CTRL_ADDR, 8'h40);
    @(negedge clk);
    ce = 1'b0;
    host.write_reg(POWER_CTRL_ADDR, 8'h20);
    ce = 1'b1;
    check_reg(POWER_CTRL_ADDR, 8'h40);
    chip_enable_pin = 1'b0;
    repeat (4) @(negedge clk);
    host.write_reg(PROTO_SEL_ADDR, 8'h21);
    `CHK("reload_refused", 1'b0, option_reload)
    check_reg(POWER_CTRL_ADDR, POWER_CTRL_RST);
    check_reg(PROTO_SEL_ADDR, PROTO_SEL_RST);
    chip_enable_pin = 1'b1;
    repeat (4) @(negedge clk);
    $display("t_refused done");
  endtask

  task automatic t_midreset();
    host.write_reg(POWER_CTRL_ADDR, 8'hB0);
    t_proto(8'h3B, CLS_NFC, RATE_424, 1'b1, 1'b0);
    do_reset();
    check_reg(POWER_CTRL_ADDR, POWER_CTRL_RST);
    `CHK("rf_reset", exp_rf(8'h01, 8'h02), rf_ctrl)
    judge_proto(8'h02, CLS_VICINITY, RATE_106, 1'b1, 1'b1);
    $display("t_midreset done");
  endtask

  // ------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results();
  end

  initial
  begin
    clk             = 1'b0;
    nrst            = 1'b0;
    ce              = 1'b1;
    chip_enable_pin = 1'b1;
    miscompares     = 0;
    num_checks      = 0;
    do_reset();
    t_presets();
    t_power();
    t_protocols();
    t_raw();
    t_refused();
    t_midreset();
    results();
  end
endmodule
